// ---- rtl/tcs_common.sv ----
// What this block does
// - everything moves on the transaction clock rising edge
// - transaction clock runs from power-on, reset-independent
// - clock rate fixed, no change on retrain
// - reset asserts asynchronously, releases synchronously
// - in-band hot reset or disable asserts reset
// - link-up low only when both ends ready
// - link-up high while training or after errors
// - hot reset or disable drops link, flushes TLPs
// - three 8-bit header, three 12-bit data counts
// - select 000/001/010 gives receive free/granted/consumed
// - select 100/101/110 gives transmit available/limit/consumed
// - clock rate checked against lanes and speed, flagged in status only
// - clock rate one value fixed at build
//
// tcs_common: reset sequencing, link-up indication, credit views, status registers.
// assumes link status inputs and credit views are synchronous to ref_clk_i,
// and an Avalon-MM master with word addressing on the register port.
`timescale 1ns/1ps
module tcs_common #(
    parameter int LANES = 1,
    parameter bit GEN2 = 1'b0,
    parameter bit ENDPOINT = 1'b1,
    parameter int TRN_CLK_KHZ = 62500
) (
    // clock and system reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // transaction clock, reset and link-up toward user logic
    output wire logic trn_clk_o,
    output wire logic trn_reset_n_o,
    output wire logic lnk_up_n_o,
    output wire logic tlp_flush_o,
    // link layer status
    input wire logic link_trained_i,
    input wire logic link_error_i,
    input wire logic hot_reset_i,
    input wire logic link_disable_i,
    // credit views, index 0 posted, 1 non-posted, 2 completion
    input wire logic [2:0][tcs_pkg::HDR_W-1:0] rx_free_hdr_i,
    input wire logic [2:0][tcs_pkg::DATA_W-1:0] rx_free_data_i,
    input wire logic [2:0][tcs_pkg::HDR_W-1:0] rx_granted_hdr_i,
    input wire logic [2:0][tcs_pkg::DATA_W-1:0] rx_granted_data_i,
    input wire logic [2:0][tcs_pkg::HDR_W-1:0] rx_consumed_hdr_i,
    input wire logic [2:0][tcs_pkg::DATA_W-1:0] rx_consumed_data_i,
    input wire logic [2:0][tcs_pkg::HDR_W-1:0] tx_limit_hdr_i,
    input wire logic [2:0][tcs_pkg::DATA_W-1:0] tx_limit_data_i,
    input wire logic [2:0][tcs_pkg::HDR_W-1:0] tx_consumed_hdr_i,
    input wire logic [2:0][tcs_pkg::DATA_W-1:0] tx_consumed_data_i,
    // credit select and picked figures
    input wire logic [2:0] credit_view_select_i,
    output wire logic [tcs_pkg::HDR_W-1:0] posted_hdr_credits_o,
    output wire logic [tcs_pkg::DATA_W-1:0] posted_data_credits_o,
    output wire logic [tcs_pkg::HDR_W-1:0] nonposted_hdr_credits_o,
    output wire logic [tcs_pkg::DATA_W-1:0] nonposted_data_credits_o,
    output wire logic [tcs_pkg::HDR_W-1:0] completion_hdr_credits_o,
    output wire logic [tcs_pkg::DATA_W-1:0] completion_data_credits_o,
    // avalon-mm slave, word address
    input wire logic [2:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output wire logic [31:0] avs_readdata_o,
    output wire logic avs_waitrequest_o,
    // interrupt
    output wire logic irq_o
);

    // ==========================================================
    // clock forwarding and build-time rate check
    // the forwarded clock has no gate and no reset term, so nothing can stop it
    assign trn_clk_o = ref_clk_i;
    // rate is a parameter only, never changed by link events
    localparam logic FREQ_OK = tcs_pkg::tcs_freq_ok(LANES, GEN2, TRN_CLK_KHZ, ENDPOINT);

    // ==========================================================
    // declarations
    logic sync1_r;
    logic sync2_r;
    logic rst_out_r;
    logic rst_out_nxt;
    logic inband;
    logic lnk_up_n_r;
    logic lnk_up_n_nxt;
    logic flush_r;
    tcs_pkg::tcs_link_t state_r;
    tcs_pkg::tcs_link_t state_nxt;
    logic [1:0] ctrl_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic [2:0] irq_ev;
    logic [2:0] irq_clr;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic bus_req;
    logic wr_take;

    assign inband = hot_reset_i | link_disable_i;

    // ==========================================================
    // transaction reset: async assert, two-stage synchronous release
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= 1'b1;
            sync2_r <= sync1_r;
        end
    end

    // in-band events and the soft reset bit pull the output low one edge later
    assign rst_out_nxt = sync2_r & ~inband & ~ctrl_r[tcs_pkg::CTRL_SOFT_RST];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_out_r <= 1'b0;
        end else begin
            rst_out_r <= rst_out_nxt;
        end
    end
    // user side must idle while this is low; nothing here depends on it
    assign trn_reset_n_o = rst_out_r;

    // ==========================================================
    // link state machine
    always_comb begin
        state_nxt = state_r;
        if (inband) begin
            state_nxt = tcs_pkg::LNK_FLUSH;
        end else if (!rst_out_nxt) begin
            state_nxt = tcs_pkg::LNK_RESET;
        end else begin
            case (state_r)
                tcs_pkg::LNK_RESET: begin
                    state_nxt = tcs_pkg::LNK_TRAIN;
                end
                tcs_pkg::LNK_TRAIN: begin
                    if (link_trained_i && !link_error_i && !ctrl_r[tcs_pkg::CTRL_LINK_HOLD]) begin
                        state_nxt = tcs_pkg::LNK_UP;
                    end
                end
                tcs_pkg::LNK_UP: begin
                    if (!link_trained_i || link_error_i || ctrl_r[tcs_pkg::CTRL_LINK_HOLD]) begin
                        state_nxt = tcs_pkg::LNK_TRAIN;
                    end
                end
                tcs_pkg::LNK_FLUSH: begin
                    state_nxt = tcs_pkg::LNK_RESET;
                end
                default: begin
                    state_nxt = tcs_pkg::LNK_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= tcs_pkg::LNK_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // link-up and flush flops, driven from the next state so they move together
    assign lnk_up_n_nxt = (state_nxt != tcs_pkg::LNK_UP);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lnk_up_n_r <= 1'b1;
            flush_r <= 1'b0;
        end else begin
            lnk_up_n_r <= lnk_up_n_nxt;
            flush_r <= (state_nxt == tcs_pkg::LNK_FLUSH);
        end
    end
    assign lnk_up_n_o = lnk_up_n_r;
    assign tlp_flush_o = flush_r;

    // ==========================================================
    // credit picker
    tcs_credit_if #(.HDR_W(tcs_pkg::HDR_W), .DATA_W(tcs_pkg::DATA_W)) cif ();

    assign cif.sel = credit_view_select_i;
    assign cif.hdr_view = {tx_consumed_hdr_i, tx_limit_hdr_i, rx_consumed_hdr_i, rx_granted_hdr_i, rx_free_hdr_i};
    assign cif.data_view = {tx_consumed_data_i, tx_limit_data_i, rx_consumed_data_i, rx_granted_data_i,
                            rx_free_data_i};

    tcs_credit_view u_credit (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .cif(cif.pick)
    );

    // six outputs, widths fixed per class kind
    assign posted_hdr_credits_o = cif.hdr_out[tcs_pkg::CLS_POSTED];
    assign posted_data_credits_o = cif.data_out[tcs_pkg::CLS_POSTED];
    assign nonposted_hdr_credits_o = cif.hdr_out[tcs_pkg::CLS_NONPOSTED];
    assign nonposted_data_credits_o = cif.data_out[tcs_pkg::CLS_NONPOSTED];
    assign completion_hdr_credits_o = cif.hdr_out[tcs_pkg::CLS_COMPLETION];
    assign completion_data_credits_o = cif.data_out[tcs_pkg::CLS_COMPLETION];

    // ==========================================================
    // avalon slave: one wait cycle, then the answer
    assign bus_req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack_r;
    // writes land only on the edge where waitrequest is low
    assign wr_take = avs_write_i & ack_r & avs_byteenable_i[0];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case ({avs_address_i, 2'b00})
            tcs_pkg::OFF_CTRL: rdata_nxt[1:0] = ctrl_r;
            tcs_pkg::OFF_STATUS: begin
                rdata_nxt[tcs_pkg::ST_LINK_UP] = ~lnk_up_n_r;
                rdata_nxt[tcs_pkg::ST_RST_DONE] = rst_out_r;
                rdata_nxt[tcs_pkg::ST_FREQ_OK] = FREQ_OK;
                rdata_nxt[tcs_pkg::ST_FLUSH] = flush_r;
                rdata_nxt[tcs_pkg::ST_SEL_LSB +: 3] = credit_view_select_i;
            end
            tcs_pkg::OFF_IRQ_STAT: rdata_nxt[2:0] = irq_stat_r;
            tcs_pkg::OFF_IRQ_MASK: rdata_nxt[2:0] = irq_mask_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // read data caught in the wait cycle so it stands at the answering edge
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read_i && !ack_r) begin
            rdata_r <= rdata_nxt;
        end
    end
    assign avs_readdata_o = rdata_r;

    // control and mask registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= tcs_pkg::CTRL_RST;
            irq_mask_r <= tcs_pkg::IRQ_MASK_RST;
        end else if (wr_take) begin
            if ({avs_address_i, 2'b00} == tcs_pkg::OFF_CTRL) begin
                ctrl_r <= avs_writedata_i[1:0];
            end
            if ({avs_address_i, 2'b00} == tcs_pkg::OFF_IRQ_MASK) begin
                irq_mask_r <= avs_writedata_i[2:0];
            end
        end
    end

    // ==========================================================
    // interrupts: sticky events, write one to clear, set beats clear
    assign irq_ev[tcs_pkg::IRQ_LINK_GAIN] = lnk_up_n_r & ~lnk_up_n_nxt;
    assign irq_ev[tcs_pkg::IRQ_LINK_LOSS] = ~lnk_up_n_r & lnk_up_n_nxt;
    assign irq_ev[tcs_pkg::IRQ_INBAND] = (state_nxt == tcs_pkg::LNK_FLUSH) & ~flush_r;
    assign irq_clr = (wr_take && {avs_address_i, 2'b00} == tcs_pkg::OFF_IRQ_STAT) ? avs_writedata_i[2:0] : 3'h0;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_r <= 3'h0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
        end
    end
    assign irq_o = |(irq_stat_r & irq_mask_r);

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    inband_reset_a: assert property (inband |=> !trn_reset_n_o)
        else $error("in-band event did not assert transaction reset");
    reset_release_a: assert property ($rose(trn_reset_n_o) |-> $past(sync2_r) && !$past(inband))
        else $error("transaction reset released out of sequence");
    linkup_ready_a: assert property (!lnk_up_n_o |-> trn_reset_n_o && $past(link_trained_i))
        else $error("link-up without ready link");
    linkup_error_a: assert property (link_error_i || !link_trained_i |=> lnk_up_n_o)
        else $error("link-up stayed low after loss");
    flush_drop_a: assert property (inband |=> tlp_flush_o && lnk_up_n_o)
        else $error("in-band event did not flush and drop link");
    bus_answer_a: assert property ($rose(bus_req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");
    irq_gain_a: assert property (irq_ev[0] |=> irq_stat_r[0] ##0 (irq_mask_r[0] -> irq_o))
        else $error("link gain not latched into interrupt");
    soft_reset_a: assert property (ctrl_r[tcs_pkg::CTRL_SOFT_RST] |=> !trn_reset_n_o)
        else $error("soft reset bit did not hold transaction reset");

    link_up_c: cover property ($fell(lnk_up_n_o));
    hot_reset_c: cover property (!lnk_up_n_o ##1 hot_reset_i ##1 tlp_flush_o);
    irq_clear_c: cover property (irq_stat_r[1] ##1 !irq_stat_r[1]);

endmodule : tcs_common

// ---- rtl/tcs_pkg.sv ----
// tcs_pkg: shared constants for the transaction common status block.
// assumes a single 10 MHz reference clock and a word-addressed Avalon-MM slave.
package tcs_pkg;

    // ==========================================================
    // clock and widths
    localparam int REF_CLK_HZ = 10_000_000;
    localparam int HDR_W = 8;
    localparam int DATA_W = 12;
    localparam int N_CLASS = 3;
    localparam int N_VIEW = 5;

    // ==========================================================
    // traffic class index inside the packed credit arrays
    localparam int CLS_POSTED = 0;
    localparam int CLS_NONPOSTED = 1;
    localparam int CLS_COMPLETION = 2;

    // index of each supplied credit view
    localparam int VIEW_RX_FREE = 0;
    localparam int VIEW_RX_GRANTED = 1;
    localparam int VIEW_RX_CONSUMED = 2;
    localparam int VIEW_TX_LIMIT = 3;
    localparam int VIEW_TX_CONSUMED = 4;

    // credit view select codes
    localparam logic [2:0] SEL_RX_FREE = 3'h0;
    localparam logic [2:0] SEL_RX_GRANTED = 3'h1;
    localparam logic [2:0] SEL_RX_CONSUMED = 3'h2;
    localparam logic [2:0] SEL_TX_AVAIL = 3'h4;
    localparam logic [2:0] SEL_TX_LIMIT = 3'h5;
    localparam logic [2:0] SEL_TX_CONSUMED = 3'h6;

    // ==========================================================
    // register map, byte offsets
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h0C;

    // field positions
    localparam int CTRL_SOFT_RST = 0;
    localparam int CTRL_LINK_HOLD = 1;
    localparam int ST_LINK_UP = 0;
    localparam int ST_RST_DONE = 1;
    localparam int ST_FREQ_OK = 2;
    localparam int ST_FLUSH = 3;
    localparam int ST_SEL_LSB = 4;
    localparam int IRQ_LINK_GAIN = 0;
    localparam int IRQ_LINK_LOSS = 1;
    localparam int IRQ_INBAND = 2;

    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // link state machine, one-hot
    typedef enum logic [3:0] {
        LNK_RESET = 4'h1,
        LNK_TRAIN = 4'h2,
        LNK_UP = 4'h4,
        LNK_FLUSH = 4'h8
    } tcs_link_t;

    // legal transaction clock rate for a lane count and speed, in kHz
    function automatic logic tcs_freq_ok(input int lanes, input bit gen2, input int khz, input bit endpoint);
        logic ok;
        ok = 1'b0;
        if (lanes == 1 && !gen2) begin
            ok = (khz == 62500) || (khz == 125000) || (khz == 250000) || (khz == 31250 && endpoint);
        end else if ((lanes == 1 && gen2) || (lanes == 2 && !gen2)) begin
            ok = (khz == 62500) || (khz == 125000) || (khz == 250000);
        end else if ((lanes == 2 && gen2) || (lanes == 4 && !gen2)) begin
            ok = (khz == 125000) || (khz == 250000);
        end else if (lanes == 4 || lanes == 8) begin
            ok = (khz == 250000);
        end
        return ok;
    endfunction : tcs_freq_ok

endpackage : tcs_pkg

// ---- rtl/tcs_credit_if.sv ----
// tcs_credit_if: credit views and select between the top and the credit picker.
// assumes both ends sit in the reference clock domain.
`timescale 1ns/1ps
interface tcs_credit_if #(
    parameter int HDR_W = 8,
    parameter int DATA_W = 12
);
    // ==========================================================
    // select and raw views
    logic [2:0] sel;
    logic [4:0][2:0][HDR_W-1:0] hdr_view;
    logic [4:0][2:0][DATA_W-1:0] data_view;
    // picked figures, per class
    logic [2:0][HDR_W-1:0] hdr_out;
    logic [2:0][DATA_W-1:0] data_out;

    modport feed (output sel, output hdr_view, output data_view, input hdr_out, input data_out);
    modport pick (input sel, input hdr_view, input data_view, output hdr_out, output data_out);
endinterface : tcs_credit_if

// ---- rtl/tcs_credit_view.sv ----
// tcs_credit_view: registered picker for the six credit figures.
// assumes views are stable synchronous inputs on ref_clk_i.
`timescale 1ns/1ps
module tcs_credit_view (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // credit bundle
    tcs_credit_if.pick cif
);

    // ==========================================================
    // one picker per traffic class
    for (genvar c = 0; c < tcs_pkg::N_CLASS; c++) begin : g_class
        // transmit available is limit minus consumed, modulo the field width
        always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cif.hdr_out[c] <= '0;
                cif.data_out[c] <= '0;
            end else begin
                case (cif.sel)
                    tcs_pkg::SEL_RX_FREE: begin
                        cif.hdr_out[c] <= cif.hdr_view[tcs_pkg::VIEW_RX_FREE][c];
                        cif.data_out[c] <= cif.data_view[tcs_pkg::VIEW_RX_FREE][c];
                    end
                    tcs_pkg::SEL_RX_GRANTED: begin
                        cif.hdr_out[c] <= cif.hdr_view[tcs_pkg::VIEW_RX_GRANTED][c];
                        cif.data_out[c] <= cif.data_view[tcs_pkg::VIEW_RX_GRANTED][c];
                    end
                    tcs_pkg::SEL_RX_CONSUMED: begin
                        cif.hdr_out[c] <= cif.hdr_view[tcs_pkg::VIEW_RX_CONSUMED][c];
                        cif.data_out[c] <= cif.data_view[tcs_pkg::VIEW_RX_CONSUMED][c];
                    end
                    tcs_pkg::SEL_TX_AVAIL: begin
                        cif.hdr_out[c] <= cif.hdr_view[tcs_pkg::VIEW_TX_LIMIT][c]
                                          - cif.hdr_view[tcs_pkg::VIEW_TX_CONSUMED][c];
                        cif.data_out[c] <= cif.data_view[tcs_pkg::VIEW_TX_LIMIT][c]
                                           - cif.data_view[tcs_pkg::VIEW_TX_CONSUMED][c];
                    end
                    tcs_pkg::SEL_TX_LIMIT: begin
                        cif.hdr_out[c] <= cif.hdr_view[tcs_pkg::VIEW_TX_LIMIT][c];
                        cif.data_out[c] <= cif.data_view[tcs_pkg::VIEW_TX_LIMIT][c];
                    end
                    tcs_pkg::SEL_TX_CONSUMED: begin
                        cif.hdr_out[c] <= cif.hdr_view[tcs_pkg::VIEW_TX_CONSUMED][c];
                        cif.data_out[c] <= cif.data_view[tcs_pkg::VIEW_TX_CONSUMED][c];
                    end
                    // undefined codes read as zero rather than stale data
                    default: begin
                        cif.hdr_out[c] <= '0;
                        cif.data_out[c] <= '0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    rx_free_pick_a: assert property (cif.sel == tcs_pkg::SEL_RX_FREE |=>
        cif.data_out[0] == $past(cif.data_view[0][0]) && cif.hdr_out[2] == $past(cif.hdr_view[0][2]))
        else $error("receive free view not presented");
    tx_avail_pick_a: assert property (cif.sel == tcs_pkg::SEL_TX_AVAIL |=>
        cif.hdr_out[1] == $past(cif.hdr_view[3][1] - cif.hdr_view[4][1]))
        else $error("transmit available view wrong");
    bad_sel_zero_a: assert property (cif.sel == 3'h3 || cif.sel == 3'h7 |=>
        cif.hdr_out == '0 && cif.data_out == '0)
        else $error("undefined select did not give zero");
    tx_view_c: cover property (cif.sel == tcs_pkg::SEL_TX_LIMIT ##1 cif.sel == tcs_pkg::SEL_RX_GRANTED);

endmodule : tcs_credit_view

// ---- bench/tcs_user_model.sv ----
// tcs_user_model: user logic stand-in that steers the credit view select.
// assumes transaction clock and reset come from tcs_common.
`timescale 1ns/1ps
module tcs_user_model (
    // transaction side
    input wire logic trn_clk_i,
    input wire logic trn_reset_n_i,
    // credit select toward the core
    output logic [2:0] sel_o = 3'h0
);
    logic [2:0] pick;
    // ==========================================================
    // random legal code each cycle; 3 and 7 skipped by remapping
    always @(posedge trn_clk_i) begin
        pick = 3'($urandom_range(5));
        if (!trn_reset_n_i) begin
            sel_o <= 3'h0;
        end else begin
            sel_o <= (pick > 3'h2) ? pick + 3'h1 : pick;
        end
    end
endmodule : tcs_user_model

// ---- bench/tb_top.sv ----
// tb_top: random credit views, link events and register traffic for tcs_common.
// assumes the design paces the register bus through waitrequest.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic trn = 1'b0, lerr = 1'b0, hot = 1'b0, dis = 1'b0, rd = 1'b0, wr = 1'b0, pok;
    logic [4:0][2:0][7:0] hv = '0, phv;
    logic [4:0][2:0][11:0] dv = '0, pdv;
    logic [4:0][11:0] hx, dx;
    logic [2:0] adr = 3'h0, sel, ps;
    logic [31:0] wd = 32'h0, q;
    wire trn_clk, trn_rst_n, up_n, flush, ws, irq;
    wire [31:0] rdata;
    wire [2:0][7:0] ch;
    wire [2:0][11:0] cd;
    int n_fail = 0, checks = 0, cyc = 0, n_trn = 0;

    tcs_common dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .trn_clk_o(trn_clk), .trn_reset_n_o(trn_rst_n),
        .lnk_up_n_o(up_n), .tlp_flush_o(flush), .link_trained_i(trn), .link_error_i(lerr), .hot_reset_i(hot),
        .link_disable_i(dis), .rx_free_hdr_i(hv[0]), .rx_free_data_i(dv[0]), .rx_granted_hdr_i(hv[1]),
        .rx_granted_data_i(dv[1]), .rx_consumed_hdr_i(hv[2]), .rx_consumed_data_i(dv[2]), .tx_limit_hdr_i(hv[3]),
        .tx_limit_data_i(dv[3]), .tx_consumed_hdr_i(hv[4]), .tx_consumed_data_i(dv[4]),
        .credit_view_select_i(sel), .posted_hdr_credits_o(ch[0]), .posted_data_credits_o(cd[0]),
        .nonposted_hdr_credits_o(ch[1]), .nonposted_data_credits_o(cd[1]), .completion_hdr_credits_o(ch[2]),
        .completion_data_credits_o(cd[2]), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(ws), .irq_o(irq));
    tcs_user_model um_u (.trn_clk_i(trn_clk), .trn_reset_n_i(trn_rst_n), .sel_o(sel));

    // ==========================================================
    // clock; fresh random views every cycle; hang guard
    initial forever #50 ref_clk_i = ~ref_clk_i;
    // forwarded clock edges, counted through reset as well
    always @(posedge trn_clk) n_trn++;
    always @(posedge ref_clk_i) begin
        hv <= 120'({$urandom, $urandom, $urandom, $urandom});
        dv <= 180'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
        pok = rst_n_i;
        ps = sel;
        phv = hv;
        pdv = dv;
        cyc++;
        if (cyc > 2000) begin
            n_fail++;
            end_of_test();
        end
    end

    // expected figure; tx available wraps at the field width
    function automatic logic [11:0] cr(input logic [2:0] s, input logic [4:0][11:0] v, input logic [11:0] m);
        case (s)
            3'h0, 3'h1, 3'h2: cr = v[s] & m;
            3'h4: cr = (v[3] - v[4]) & m;
            3'h5: cr = v[3] & m;
            3'h6: cr = v[4] & m;
            default: cr = 12'h0;
        endcase
    endfunction : cr

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // credits judged mid-cycle against the previous edge's select and views
    always @(negedge ref_clk_i) begin
        chk("trn_clk", 32'(n_trn), 32'(cyc));
        if (pok && rst_n_i) begin
            for (int c = 0; c < 3; c++) begin
                for (int k = 0; k < 5; k++) begin
                    hx[k] = {4'h0, phv[k][c]};
                    dx[k] = pdv[k][c];
                end
                chk("hdr_credit", 32'(ch[c]), 32'(cr(ps, hx, 12'h0FF)));
                chk("data_credit", 32'(cd[c]), 32'(cr(ps, dx, 12'hFFF)));
            end
        end
    end

    // one register access; request rises on the next edge, ends on the answering edge
    task automatic bus(input logic [2:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge ref_clk_i);
        end while (ws !== 1'b0);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic link(input string nm, input logic rn, input logic un);
        chk({nm, "_rst"}, 32'(trn_rst_n), 32'(rn));
        chk({nm, "_up"}, 32'(up_n), 32'(un));
    endtask : link

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // ==========================================================
    // directed sequence
    initial begin
        void'($urandom(44186));
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        trn <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 link("early", 1'b0, 1'b1);
        @(posedge ref_clk_i);
        #1 link("release", 1'b1, 1'b1);
        @(posedge ref_clk_i);
        #1 link("up", 1'b1, 1'b0);
        $display("test reset and link-up done");
        bus(3'h2, 1'b0, 32'h0, q);
        #1 chk("gain_bit", 32'(q[0]), 32'h1);
        chk("irq_masked", 32'(irq), 32'h0);
        bus(3'h3, 1'b1, 32'h7, q);
        #1 chk("irq_on", 32'(irq), 32'h1);
        bus(3'h2, 1'b1, 32'h7, q);
        #1 chk("irq_clear", 32'(irq), 32'h0);
        bus(3'h5, 1'b0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        bus(3'h1, 1'b0, 32'h0, q);
        chk("status", 32'(q[2:0]), 32'h7);
        $display("test registers done");
        @(posedge ref_clk_i);
        lerr <= 1'b1;
        @(posedge ref_clk_i);
        #1 link("error", 1'b1, 1'b1);
        chk("irq_loss", 32'(irq), 32'h1);
        @(posedge ref_clk_i);
        lerr <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1 link("relink", 1'b1, 1'b0);
        $display("test link error done");
        // hot reset first, link disable second
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk_i);
            hot <= (i == 0);
            dis <= (i == 1);
            @(posedge ref_clk_i);
            #1 link("inband", 1'b0, 1'b1);
            chk("flush", 32'(flush), 32'h1);
            @(posedge ref_clk_i);
            hot <= 1'b0;
            dis <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
            #1 link("after_inband", 1'b1, 1'b0);
        end
        $display("test in-band reset done");
        // link hold, then soft reset, then both cleared
        bus(3'h0, 1'b1, 32'h2, q);
        @(posedge ref_clk_i);
        #1 link("hold", 1'b1, 1'b1);
        bus(3'h0, 1'b1, 32'h1, q);
        @(posedge ref_clk_i);
        #1 link("soft", 1'b0, 1'b1);
        bus(3'h0, 1'b1, 32'h0, q);
        repeat (2) @(posedge ref_clk_i);
        #1 link("unsoft", 1'b1, 1'b0);
        $display("test control bits done");
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        #1 link("async", 1'b0, 1'b1);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        #1 link("rerun", 1'b1, 1'b0);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : tb_top
